// ===== src/dmau_consts.svh
// Constants for the data memory addressing unit: offsets, fields, resets
`ifndef DMAU_CONSTS_SVH
`define DMAU_CONSTS_SVH

// ============================================================
// Special purpose locations in sector 0
`define DMAU_OFS_IND0 8'h00
`define DMAU_OFS_PTR0 8'h01
`define DMAU_OFS_IND1 8'h02
`define DMAU_OFS_PTR1_LO 8'h03
`define DMAU_OFS_PTR1_SEC 8'h04
`define DMAU_OFS_ACC 8'h05
`define DMAU_OFS_BANK 8'h0b
`define DMAU_OFS_IND2 8'h0c
`define DMAU_OFS_PTR2_LO 8'h0d
`define DMAU_OFS_PTR2_SEC 8'h0e

// ============================================================
// Address layout
`define DMAU_ADDR_W 11
`define DMAU_SEC_LSB 8
`define DMAU_SEC_W 3
`define DMAU_GP_BIT 7
`define DMAU_SEC_ZERO 3'h0

// ============================================================
// Bank select field and reset values
`define DMAU_BANK_LSB 0
`define DMAU_BANK_W 2
`define DMAU_BANK_RST 2'h0
`define DMAU_REG_RST 8'h00
`define DMAU_READ_ZERO 8'h00

`endif

// ===== src/dmau_pkg.sv
// Types shared by the data memory addressing unit
package dmau_pkg;

    // ============================================================
    // Decoded location of a data memory access
    typedef enum logic [3:0] {
        DMAU_LOC_IND0 = 4'h0,
        DMAU_LOC_PTR0 = 4'h1,
        DMAU_LOC_IND1 = 4'h2,
        DMAU_LOC_PTR1_LO = 4'h3,
        DMAU_LOC_PTR1_SEC = 4'h4,
        DMAU_LOC_ACC = 4'h5,
        DMAU_LOC_BANK = 4'h6,
        DMAU_LOC_IND2 = 4'h7,
        DMAU_LOC_PTR2_LO = 4'h8,
        DMAU_LOC_PTR2_SEC = 4'h9,
        DMAU_LOC_GP = 4'ha,
        DMAU_LOC_PERIPH = 4'hb,
        DMAU_LOC_NONE = 4'hc
    } dmau_loc_type;

    // ============================================================
    // Bit operation requested with an access
    typedef enum logic [1:0] {
        DMAU_BIT_NONE = 2'h0,
        DMAU_BIT_SET = 2'h1,
        DMAU_BIT_CLR = 2'h2
    } dmau_bitop_type;

endpackage : dmau_pkg

// ===== src/dmau_gp_ram.sv
// General purpose data memory array, upper half of each sector
`timescale 1ns/10ps
`default_nettype none

module dmau_gp_ram #(
    parameter int ADDR_W = 10,
    parameter int DATA_W = 8
) (
    input wire logic clk_sys_in,
    input wire logic we_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    output logic [DATA_W-1:0] rdata_out
);

    // ============================================================
    // Storage
    logic [DATA_W-1:0] mem_ff [2**ADDR_W];

    // Asynchronous read keeps bit operations to a single cycle
    assign rdata_out = mem_ff[addr_in];

    // Contents are data only, so no reset is applied
    always_ff @(posedge clk_sys_in)
    begin
        if (we_in)
        begin
            mem_ff[addr_in] <= wdata_in;
        end
    end

endmodule : dmau_gp_ram
`default_nettype wire

// ===== src/dmau_ptr_regs.sv
// Memory pointers, accumulator and program bank select storage
`timescale 1ns/10ps
`default_nettype none

`include "dmau_consts.svh"

module dmau_ptr_regs
    import dmau_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic we_in,
    input wire dmau_loc_type sel_in,
    input wire logic [7:0] wdata_in,
    input wire logic acc_load_in,
    input wire logic [7:0] acc_data_in,
    output logic [7:0] ptr0_out,
    output logic [7:0] ptr1_lo_out,
    output logic [7:0] ptr1_sec_out,
    output logic [7:0] ptr2_lo_out,
    output logic [7:0] ptr2_sec_out,
    output logic [7:0] acc_out,
    output logic [`DMAU_BANK_W-1:0] bank_out
);

    // ============================================================
    // Register group
    logic [7:0] ptr0_ff, ptr1_lo_ff, ptr1_sec_ff, ptr2_lo_ff, ptr2_sec_ff, acc_ff;
    logic [7:0] nxt_ptr0, nxt_ptr1_lo, nxt_ptr1_sec, nxt_ptr2_lo, nxt_ptr2_sec, nxt_acc;
    logic [`DMAU_BANK_W-1:0] bank_ff, nxt_bank;

    // Next values; an ALU load wins over a memory write to the same cell
    always_comb
    begin
        nxt_ptr0 = ptr0_ff;
        nxt_ptr1_lo = ptr1_lo_ff;
        nxt_ptr1_sec = ptr1_sec_ff;
        nxt_ptr2_lo = ptr2_lo_ff;
        nxt_ptr2_sec = ptr2_sec_ff;
        nxt_acc = acc_ff;
        nxt_bank = bank_ff;
        if (we_in)
        begin
            case (sel_in)
                DMAU_LOC_PTR0: nxt_ptr0 = wdata_in;
                DMAU_LOC_PTR1_LO: nxt_ptr1_lo = wdata_in;
                DMAU_LOC_PTR1_SEC: nxt_ptr1_sec = wdata_in;
                DMAU_LOC_PTR2_LO: nxt_ptr2_lo = wdata_in;
                DMAU_LOC_PTR2_SEC: nxt_ptr2_sec = wdata_in;
                DMAU_LOC_ACC: nxt_acc = wdata_in;
                // Only the two low bits exist; the rest is dropped
                DMAU_LOC_BANK: nxt_bank = wdata_in[`DMAU_BANK_LSB +: `DMAU_BANK_W];
                default: nxt_bank = bank_ff;
            endcase
        end
        if (acc_load_in)
        begin
            nxt_acc = acc_data_in;
        end
    end

    // Registering; bank resets to bank zero
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            ptr0_ff <= `DMAU_REG_RST;
            ptr1_lo_ff <= `DMAU_REG_RST;
            ptr1_sec_ff <= `DMAU_REG_RST;
            ptr2_lo_ff <= `DMAU_REG_RST;
            ptr2_sec_ff <= `DMAU_REG_RST;
            acc_ff <= `DMAU_REG_RST;
            bank_ff <= `DMAU_BANK_RST;
        end
        else
        begin
            ptr0_ff <= nxt_ptr0;
            ptr1_lo_ff <= nxt_ptr1_lo;
            ptr1_sec_ff <= nxt_ptr1_sec;
            ptr2_lo_ff <= nxt_ptr2_lo;
            ptr2_sec_ff <= nxt_ptr2_sec;
            acc_ff <= nxt_acc;
            bank_ff <= nxt_bank;
        end
    end

    assign ptr0_out = ptr0_ff;
    assign ptr1_lo_out = ptr1_lo_ff;
    assign ptr1_sec_out = ptr1_sec_ff;
    assign ptr2_lo_out = ptr2_lo_ff;
    assign ptr2_sec_out = ptr2_sec_ff;
    assign acc_out = acc_ff;
    assign bank_out = bank_ff;

endmodule : dmau_ptr_regs
`default_nettype wire

// ===== src/dmau_top.sv
// Data memory addressing unit: direct, extended and indirect access
`timescale 1ns/10ps
`default_nettype none

`include "dmau_consts.svh"

module dmau_top
    import dmau_pkg::*;
#(
    parameter int SECTORS = 8,
    parameter int PAGE_W = 11
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic mem_req_in,
    input wire logic mem_we_in,
    input wire logic mem_ext_in,
    input wire logic [`DMAU_ADDR_W-1:0] mem_addr_in,
    input wire logic [7:0] mem_wdata_in,
    input wire dmau_bitop_type mem_bitop_in,
    input wire logic [2:0] mem_bit_in,
    output logic [7:0] mem_rdata_out,
    output logic mem_rvalid_out,
    input wire logic acc_load_in,
    input wire logic [7:0] alu_result_in,
    output logic [7:0] acc_out,
    input wire logic branch_in,
    input wire logic [PAGE_W-1:0] branch_target_in,
    output logic [PAGE_W+`DMAU_BANK_W-1:0] branch_addr_out,
    output logic branch_valid_out,
    output logic [`DMAU_BANK_W-1:0] bank_sel_out,
    output logic periph_sel_out,
    output logic periph_we_out,
    output logic [`DMAU_ADDR_W-1:0] periph_addr_out,
    output logic [7:0] periph_wdata_out,
    input wire logic [7:0] periph_rdata_in,
    input wire logic periph_hit_in,
    input wire logic periph_ro_in
);

    // ============================================================
    // Elaboration checks
    localparam int GP_ADDR_W = `DMAU_SEC_W + `DMAU_GP_BIT;

    generate
        if (SECTORS != (1 << `DMAU_SEC_W))
        begin : g_bad_sectors
            $error("dmau_top: SECTORS must equal the sector field range");
        end
        if (PAGE_W < 1)
        begin : g_bad_page
            $error("dmau_top: PAGE_W must be at least one");
        end
    endgenerate

    // ============================================================
    // Location decode, used for the direct and the resolved address
    function automatic dmau_loc_type decode_loc(input logic [`DMAU_ADDR_W-1:0] addr);
        logic [7:0] ofs;
        logic [`DMAU_SEC_W-1:0] sec;
        ofs = addr[7:0];
        sec = addr[`DMAU_SEC_LSB +: `DMAU_SEC_W];
        decode_loc = DMAU_LOC_PERIPH;
        if (ofs[`DMAU_GP_BIT])
        begin
            decode_loc = DMAU_LOC_GP;
        end
        else if (sec == `DMAU_SEC_ZERO)
        begin
            case (ofs)
                `DMAU_OFS_IND0: decode_loc = DMAU_LOC_IND0;
                `DMAU_OFS_PTR0: decode_loc = DMAU_LOC_PTR0;
                `DMAU_OFS_IND1: decode_loc = DMAU_LOC_IND1;
                `DMAU_OFS_PTR1_LO: decode_loc = DMAU_LOC_PTR1_LO;
                `DMAU_OFS_PTR1_SEC: decode_loc = DMAU_LOC_PTR1_SEC;
                `DMAU_OFS_ACC: decode_loc = DMAU_LOC_ACC;
                `DMAU_OFS_BANK: decode_loc = DMAU_LOC_BANK;
                `DMAU_OFS_IND2: decode_loc = DMAU_LOC_IND2;
                `DMAU_OFS_PTR2_LO: decode_loc = DMAU_LOC_PTR2_LO;
                `DMAU_OFS_PTR2_SEC: decode_loc = DMAU_LOC_PTR2_SEC;
                default: decode_loc = DMAU_LOC_PERIPH;
            endcase
        end
    endfunction : decode_loc

    // True for the three locations that only redirect
    function automatic logic is_port(input dmau_loc_type loc);
        is_port = (loc == DMAU_LOC_IND0) || (loc == DMAU_LOC_IND1) ||
            (loc == DMAU_LOC_IND2);
    endfunction : is_port

    // ============================================================
    // Register storage and general purpose memory
    logic [7:0] ptr0, ptr1_lo, ptr1_sec, ptr2_lo, ptr2_sec, acc_val;
    logic [`DMAU_BANK_W-1:0] bank_val;
    logic [7:0] gp_rdata;
    logic reg_we, gp_we;
    dmau_loc_type final_loc;
    logic [7:0] new_data;
    logic [`DMAU_ADDR_W-1:0] final_addr;

    dmau_ptr_regs u_regs (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .we_in(reg_we),
        .sel_in(final_loc),
        .wdata_in(new_data),
        .acc_load_in(acc_load_in),
        .acc_data_in(alu_result_in),
        .ptr0_out(ptr0),
        .ptr1_lo_out(ptr1_lo),
        .ptr1_sec_out(ptr1_sec),
        .ptr2_lo_out(ptr2_lo),
        .ptr2_sec_out(ptr2_sec),
        .acc_out(acc_val),
        .bank_out(bank_val)
    );

    // General storage is indexed by sector and the low seven offset bits
    dmau_gp_ram #(
        .ADDR_W(GP_ADDR_W),
        .DATA_W(8)
    ) u_gp_ram (
        .clk_sys_in(clk_sys_in),
        .we_in(gp_we),
        .addr_in({final_addr[`DMAU_SEC_LSB +: `DMAU_SEC_W], final_addr[6:0]}),
        .wdata_in(new_data),
        .rdata_out(gp_rdata)
    );

    // ============================================================
    // Address formation
    logic [`DMAU_ADDR_W-1:0] direct_addr;
    dmau_loc_type direct_loc;
    logic [7:0] sec_byte;
    logic sec_bad;

    // Standard operands see sector zero; extended ones carry the sector
    always_comb
    begin
        if (mem_ext_in)
        begin
            direct_addr = mem_addr_in;
        end
        else
        begin
            direct_addr = {`DMAU_SEC_ZERO, mem_addr_in[7:0]};
        end
        direct_loc = decode_loc(direct_addr);
    end

    // Redirect through the pointer paired with the port
    always_comb
    begin
        final_addr = direct_addr;
        sec_byte = 8'h00;
        sec_bad = 1'b0;
        case (direct_loc)
            DMAU_LOC_IND0:
            begin
                final_addr = {`DMAU_SEC_ZERO, ptr0};
            end
            DMAU_LOC_IND1:
            begin
                sec_byte = ptr1_sec;
                final_addr = {ptr1_sec[`DMAU_SEC_W-1:0], ptr1_lo};
            end
            DMAU_LOC_IND2:
            begin
                sec_byte = ptr2_sec;
                final_addr = {ptr2_sec[`DMAU_SEC_W-1:0], ptr2_lo};
            end
            default:
            begin
                final_addr = direct_addr;
            end
        endcase
        // A sector past the implemented range is treated as unused
        sec_bad = (sec_byte[7:`DMAU_SEC_W] != 5'h00);
    end

    // Port aimed at a port, or a sector that does not exist, hits nothing
    always_comb
    begin
        final_loc = decode_loc(final_addr);
        if (sec_bad || (is_port(direct_loc) && is_port(final_loc)))
        begin
            final_loc = DMAU_LOC_NONE;
        end
    end

    // ============================================================
    // Read selection and bit modify
    logic [7:0] old_data;
    logic do_write;

    always_comb
    begin
        case (final_loc)
            DMAU_LOC_PTR0: old_data = ptr0;
            DMAU_LOC_PTR1_LO: old_data = ptr1_lo;
            DMAU_LOC_PTR1_SEC: old_data = ptr1_sec;
            DMAU_LOC_PTR2_LO: old_data = ptr2_lo;
            DMAU_LOC_PTR2_SEC: old_data = ptr2_sec;
            DMAU_LOC_ACC: old_data = acc_val;
            // Upper six bits have no flops behind them
            DMAU_LOC_BANK: old_data = {6'h00, bank_val};
            DMAU_LOC_GP: old_data = gp_rdata;
            // Unmapped peripheral addresses read back as zero
            DMAU_LOC_PERIPH: old_data = periph_hit_in ? periph_rdata_in : `DMAU_READ_ZERO;
            default: old_data = `DMAU_READ_ZERO;
        endcase
    end

    // Bit set and clear are read-modify-write on the resolved location
    always_comb
    begin
        new_data = mem_wdata_in;
        case (mem_bitop_in)
            DMAU_BIT_SET: new_data = old_data | (8'h01 << mem_bit_in);
            DMAU_BIT_CLR: new_data = old_data & ~(8'h01 << mem_bit_in);
            default: new_data = mem_wdata_in;
        endcase
        do_write = mem_req_in && (mem_we_in || (mem_bitop_in != DMAU_BIT_NONE));
    end

    // ============================================================
    // Write strobes
    // Memory writes take the operand from the core, never from another
    // location, so copies between two registers go through the accumulator
    always_comb
    begin
        gp_we = do_write && (final_loc == DMAU_LOC_GP);
        reg_we = do_write && (final_loc != DMAU_LOC_GP) &&
            (final_loc != DMAU_LOC_PERIPH) && (final_loc != DMAU_LOC_NONE);
        periph_sel_out = mem_req_in && (final_loc == DMAU_LOC_PERIPH);
        // Unused or read-only peripheral locations get no write strobe
        periph_we_out = do_write && (final_loc == DMAU_LOC_PERIPH) &&
            periph_hit_in && !periph_ro_in;
        periph_addr_out = final_addr;
        periph_wdata_out = new_data;
    end

    // ============================================================
    // Read data return
    logic [7:0] rdata_ff, nxt_rdata;
    logic rvalid_ff, nxt_rvalid;

    // Read data shows the value before any write of the same access
    always_comb
    begin
        nxt_rdata = rdata_ff;
        nxt_rvalid = mem_req_in;
        if (mem_req_in)
        begin
            nxt_rdata = old_data;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            rdata_ff <= `DMAU_READ_ZERO;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    assign mem_rdata_out = rdata_ff;
    assign mem_rvalid_out = rvalid_ff;

    // ============================================================
    // Program branch address
    logic [PAGE_W+`DMAU_BANK_W-1:0] br_addr_ff, nxt_br_addr;
    logic br_valid_ff, nxt_br_valid;

    // The bank field applies to program fetches only; data never sees it
    always_comb
    begin
        nxt_br_addr = br_addr_ff;
        nxt_br_valid = branch_in;
        if (branch_in)
        begin
            nxt_br_addr = {bank_val, branch_target_in};
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            br_addr_ff <= '0;
            br_valid_ff <= 1'b0;
        end
        else
        begin
            br_addr_ff <= nxt_br_addr;
            br_valid_ff <= nxt_br_valid;
        end
    end

    assign branch_addr_out = br_addr_ff;
    assign branch_valid_out = br_valid_ff;
    assign bank_sel_out = bank_val;
    assign acc_out = acc_val;

endmodule : dmau_top
`default_nettype wire

// ===== verif/dmau_periph_model.sv
// Peripheral register file model behind the unit's peripheral port
`timescale 1ns/10ps
`default_nettype none

module dmau_periph_model (
    input wire logic clk_sys_in,
    input wire logic periph_we_in,
    input wire logic [10:0] periph_addr_in,
    input wire logic [7:0] periph_wdata_in,
    output logic [7:0] periph_rdata_out,
    output logic periph_hit_out,
    output logic periph_ro_out
);
    logic [7:0] mem_ff [0:63];
    logic [7:0] junk_ff = 8'h5a;

    initial for (int i = 0; i < 64; i++) mem_ff[i] = 8'h00;

    // ============================================================
    // Decode: offsets 10h-3fh live here, aliased in every sector
    assign periph_hit_out = periph_addr_in[7:0] >= 8'h10 && periph_addr_in[7:0] < 8'h40;
    assign periph_ro_out = periph_addr_in[4:0] == 5'h1f;
    // Unused places show a changing pattern so a stale zero cannot pass
    assign periph_rdata_out = periph_hit_out ? mem_ff[periph_addr_in[5:0]] : junk_ff;

    // Storage takes whatever the strobe says; no mercy for a bad strobe
    always @(posedge clk_sys_in)
    begin
        junk_ff <= ~junk_ff + 8'h01;
        if (periph_we_in) mem_ff[periph_addr_in[5:0]] <= periph_wdata_in;
    end
endmodule : dmau_periph_model
`default_nettype wire

// ===== verif/dmau_top_properties.sv
// Port-level timing and routing checks for the addressing unit
`timescale 1ns/10ps
`default_nettype none

`include "dmau_consts.svh"

module dmau_top_properties
    import dmau_pkg::*;
#(
    parameter int SECTORS = 8,
    parameter int PAGE_W = 11
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic mem_req_in,
    input wire logic mem_we_in,
    input wire logic mem_ext_in,
    input wire logic [`DMAU_ADDR_W-1:0] mem_addr_in,
    input wire logic [7:0] mem_wdata_in,
    input wire dmau_bitop_type mem_bitop_in,
    input wire logic [2:0] mem_bit_in,
    input wire logic [7:0] mem_rdata_out,
    input wire logic mem_rvalid_out,
    input wire logic acc_load_in,
    input wire logic [7:0] alu_result_in,
    input wire logic [7:0] acc_out,
    input wire logic branch_in,
    input wire logic [PAGE_W-1:0] branch_target_in,
    input wire logic [PAGE_W+`DMAU_BANK_W-1:0] branch_addr_out,
    input wire logic branch_valid_out,
    input wire logic [`DMAU_BANK_W-1:0] bank_sel_out,
    input wire logic periph_sel_out,
    input wire logic periph_we_out,
    input wire logic [`DMAU_ADDR_W-1:0] periph_addr_out,
    input wire logic [7:0] periph_wdata_out,
    input wire logic periph_hit_in,
    input wire logic periph_ro_in
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    // ============================================================
    // Single-cycle sequences, chained by the assertions below
    sequence ptr_write_s;
        mem_req_in && mem_we_in && !mem_ext_in && mem_addr_in[7:0] == `DMAU_OFS_PTR0
            && mem_bitop_in == DMAU_BIT_NONE;
    endsequence
    sequence ptr_read_s;
        mem_req_in && !mem_we_in && !mem_ext_in && mem_addr_in[7:0] == `DMAU_OFS_PTR0
            && mem_bitop_in == DMAU_BIT_NONE;
    endsequence
    sequence gp_set_s;
        mem_req_in && mem_ext_in && mem_addr_in[7] && mem_bitop_in == DMAU_BIT_SET;
    endsequence
    sequence same_read_s;
        mem_req_in && !mem_we_in && mem_ext_in && mem_bitop_in == DMAU_BIT_NONE
            && mem_addr_in == $past(mem_addr_in);
    endsequence

    // ============================================================
    // Assertions
    rvalid_pulse_a: assert property (1'b1 |=> mem_rvalid_out == $past(mem_req_in))
        else $error("read valid does not follow request");
    ptr_store_a: assert property (ptr_write_s ##1 ptr_read_s |=>
        mem_rdata_out == $past(mem_wdata_in, 2)) else $error("pointer lost its value");
    bit_set_a: assert property (gp_set_s ##1 same_read_s |=>
        mem_rdata_out[$past(mem_bit_in, 2)]) else $error("bit set not stored");
    bank_read_a: assert property (mem_req_in && !mem_ext_in &&
        mem_addr_in[7:0] == `DMAU_OFS_BANK |=> mem_rdata_out == {6'h00, $past(bank_sel_out)})
        else $error("bank register read wrong");
    branch_bank_a: assert property (branch_in |=> branch_valid_out &&
        branch_addr_out == {$past(bank_sel_out), $past(branch_target_in)})
        else $error("branch address wrong");
    acc_load_a: assert property (acc_load_in |=> acc_out == $past(alu_result_in))
        else $error("accumulator load wrong");
    ext_direct_a: assert property (mem_req_in && mem_ext_in && !mem_addr_in[7] &&
        mem_addr_in[6:4] != 3'h0 |-> periph_sel_out && periph_addr_out == mem_addr_in)
        else $error("extended address not passed through");
    ro_guard_a: assert property (periph_ro_in |-> !periph_we_out)
        else $error("write strobe to read-only place");
    unused_drop_a: assert property (!periph_hit_in |-> !periph_we_out)
        else $error("write strobe to unused place");
    unused_zero_a: assert property (mem_req_in && periph_sel_out && !periph_hit_in
        |=> mem_rdata_out == 8'h00) else $error("unused place did not read zero");
    periph_write_a: assert property (mem_req_in && mem_we_in && periph_sel_out &&
        mem_bitop_in == DMAU_BIT_NONE && periph_hit_in && !periph_ro_in
        |-> periph_we_out && periph_wdata_out == mem_wdata_in) else $error("peripheral write lost");
endmodule : dmau_top_properties

bind dmau_top dmau_top_properties #(.SECTORS(SECTORS), .PAGE_W(PAGE_W)) u_props (
    .clk_sys_in, .rst_in, .mem_req_in, .mem_we_in, .mem_ext_in, .mem_addr_in, .mem_wdata_in,
    .mem_bitop_in, .mem_bit_in, .mem_rdata_out, .mem_rvalid_out, .acc_load_in, .alu_result_in,
    .acc_out, .branch_in, .branch_target_in, .branch_addr_out, .branch_valid_out, .bank_sel_out,
    .periph_sel_out, .periph_we_out, .periph_addr_out, .periph_wdata_out, .periph_hit_in,
    .periph_ro_in
);
`default_nettype wire

// ===== verif/tb_dmau_top.sv
// Testbench: random core traffic against a reference model
`timescale 1ns/10ps
`default_nettype none

`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin mismatches++; $display("mismatch %s exp %0h seen %0h", n, e, s); end end

module tb_dmau_top;
    import dmau_pkg::*;

    logic clk_sys_in = 1'b0, rst_in = 1'b1, mem_req_in = 1'b0, mem_we_in = 1'b0;
    logic mem_ext_in = 1'b0, acc_load_in = 1'b0, branch_in = 1'b0;
    logic [10:0] mem_addr_in = 11'h000, branch_target_in = 11'h000, periph_addr_out;
    logic [7:0] mem_wdata_in = 8'h00, alu_result_in = 8'h00, mem_rdata_out, acc_out;
    logic [7:0] periph_wdata_out, periph_rdata_in;
    dmau_bitop_type mem_bitop_in = DMAU_BIT_NONE;
    logic [2:0] mem_bit_in = 3'h0;
    logic [12:0] branch_addr_out;
    logic [1:0] bank_sel_out;
    logic mem_rvalid_out, branch_valid_out, periph_sel_out, periph_we_out;
    logic periph_hit_in, periph_ro_in;
    // Reference state: sector-0 registers by offset, memory and peripheral mirrors
    int rg [0:15];
    bit [7:0] gp [0:1023];
    bit gv [0:1023];
    bit [7:0] pm [0:63];
    int exp_rv, exp_rd, exp_kn, exp_bv, exp_ba, mismatches, n_tests;
    int unsigned seed = 79;
    int pool [16] = '{0, 1, 2, 3, 4, 5, 11, 12, 13, 14, 31, 35, 48, 69, 128, 129};

    initial forever #25 clk_sys_in = ~clk_sys_in;

    dmau_top #(.SECTORS(8), .PAGE_W(11)) u_dut (.clk_sys_in, .rst_in, .mem_req_in,
        .mem_we_in, .mem_ext_in, .mem_addr_in, .mem_wdata_in, .mem_bitop_in, .mem_bit_in,
        .mem_rdata_out, .mem_rvalid_out, .acc_load_in, .alu_result_in, .acc_out, .branch_in,
        .branch_target_in, .branch_addr_out, .branch_valid_out, .bank_sel_out, .periph_sel_out,
        .periph_we_out, .periph_addr_out, .periph_wdata_out, .periph_rdata_in, .periph_hit_in,
        .periph_ro_in);
    dmau_periph_model u_periph (.clk_sys_in, .periph_we_in(periph_we_out),
        .periph_addr_in(periph_addr_out), .periph_wdata_in(periph_wdata_out),
        .periph_rdata_out(periph_rdata_in), .periph_hit_out(periph_hit_in),
        .periph_ro_out(periph_ro_in));

    // ============================================================
    // Helpers
    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic give_verdict();
        if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    // Results of the previous cycle, sampled at the falling edge once settled
    task automatic check();
        `CHK("rvalid", exp_rv, mem_rvalid_out)
        if (exp_rv != 0 && exp_kn != 0) `CHK("rdata", exp_rd, mem_rdata_out)
        `CHK("bvalid", exp_bv, branch_valid_out)
        if (exp_bv != 0) `CHK("baddr", exp_ba, branch_addr_out)
        `CHK("acc", rg[5], acc_out)
        `CHK("bank", rg[11], bank_sel_out)
    endtask : check

    task automatic do_reset(input int n, input bit chk);
        @(negedge clk_sys_in);
        if (chk) check();
        rst_in = 1'b1;
        mem_req_in = 1'b0;
        acc_load_in = 1'b0;
        branch_in = 1'b0;
        repeat (n) @(negedge clk_sys_in);
        rst_in = 1'b0;
        foreach (rg[i]) rg[i] = 0;
        exp_rv = 0;
        exp_bv = 0;
        `CHK("rdata_rst", 0, mem_rdata_out)
        `CHK("baddr_rst", 0, branch_addr_out)
    endtask : do_reset

    // One core cycle: drive at the falling edge and advance the model
    task automatic op(input bit rq, we, ex, input bit [10:0] ad, input bit [7:0] wd,
        input int bo, input bit [2:0] bi, input bit al, br);
        int sec, off, rd, nv, g;
        bit kn, port;
        int unsigned r;
        @(negedge clk_sys_in);
        check();
        r = rnd();
        mem_req_in = rq;
        mem_we_in = we;
        mem_ext_in = ex;
        mem_addr_in = ad;
        mem_wdata_in = wd;
        mem_bitop_in = dmau_bitop_type'(bo);
        mem_bit_in = bi;
        acc_load_in = al;
        alu_result_in = r[7:0];
        branch_in = br;
        branch_target_in = r[18:8];
        exp_rv = rq;
        exp_bv = br;
        exp_ba = rg[11] * 2048 + r[18:8];
        kn = 1'b1;
        rd = 0;
        sec = ex ? ad[10:8] : 0;
        off = ad[7:0];
        if (sec == 0 && off == 0) off = rg[1];
        else if (sec == 0 && off == 2) {sec, off} = {rg[4], rg[3]};
        else if (sec == 0 && off == 12) {sec, off} = {rg[14], rg[13]};
        g = sec * 128 + off - 128;
        port = sec > 7 || (sec == 0 && off inside {0, 2, 12});
        if (port) rd = 0;
        else if (sec == 0 && off inside {1, 3, 4, 5, 11, 13, 14}) rd = rg[off];
        else if (off > 127) {rd, kn} = {24'h0, gp[g], gv[g]};
        else if (off > 15 && off < 64) rd = pm[off];
        nv = (bo == 1 ? rd | (1 << bi) : bo == 2 ? rd & ~(1 << bi) : wd) & 255;
        if (rq && (we || bo != 0) && !port)
        begin
            if (sec == 0 && off inside {1, 3, 4, 13, 14}) rg[off] = nv;
            else if (sec == 0 && off == 11) rg[11] = nv & 3;
            else if (sec == 0 && off == 5) rg[5] = al ? rg[5] : nv;
            else if (off > 127) {gp[g], gv[g]} = {nv[7:0], kn || bo == 0};
            else if (off > 15 && off < 64 && off % 32 != 31) pm[off] = nv;
        end
        if (al) rg[5] = r[7:0];
        exp_rd = rd;
        exp_kn = kn;
    endtask : op

    // ============================================================
    // Directed walk, then random traffic with a reset midway
    initial
    begin
        int unsigned r;
        bit [7:0] wd, o;
        do_reset(15, 1'b0);
        op(1, 1, 0, 11'h001, 8'h85, 0, 0, 0, 0);
        op(1, 0, 0, 11'h001, 8'h00, 0, 0, 0, 0);
        op(1, 1, 0, 11'h000, 8'h5a, 0, 0, 0, 0);
        op(1, 0, 1, 11'h085, 8'h00, 0, 0, 1, 1);
        op(1, 1, 0, 11'h00b, 8'hff, 0, 0, 0, 0);
        op(1, 0, 0, 11'h00b, 8'h00, 0, 0, 0, 1);
        op(1, 1, 0, 11'h001, 8'h02, 0, 0, 0, 0);
        op(1, 1, 0, 11'h000, 8'h77, 0, 0, 0, 0);
        op(1, 0, 0, 11'h000, 8'h00, 0, 0, 0, 0);
        op(1, 1, 1, 11'h385, 8'h00, 0, 0, 0, 0);
        op(1, 1, 1, 11'h385, 8'h00, 1, 3, 0, 0);
        op(1, 0, 1, 11'h385, 8'h00, 0, 0, 0, 0);
        op(1, 0, 1, 11'h385, 8'h00, 2, 3, 0, 0);
        op(1, 0, 1, 11'h385, 8'h00, 0, 0, 0, 0);
        for (int i = 0; i < 4000; i++)
        begin
            if (i == 2000) do_reset(2, 1'b1);
            r = rnd();
            o = 8'(pool[r[13:10]]);
            wd = (o == 8'h04 || o == 8'h0e) ? r[17:14] : r[21:14];
            op(r[22] | r[23], r[24], r[25], {r[6] ? r[9:7] : 3'h0, o}, wd, (r >> 26) % 3,
                r[31:29], r[28] & r[27], r[29] & r[30]);
        end
        op(0, 0, 0, 11'h000, 8'h00, 0, 0, 0, 0);
        @(negedge clk_sys_in);
        check();
        give_verdict();
    end

    // Watchdog against a hung run
    initial
    begin
        #1000000;
        mismatches++;
        give_verdict();
    end
endmodule : tb_dmau_top

`default_nettype wire
